// file: icp_parser.sv
// icp_parser: instrument command-line parser, one character per cycle.
// assumes characters come from same-clock logic; the parser holds its state while char_valid is low.
`timescale 1ns/1ns
module icp_parser
	import icp_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// character stream from the remote interface
	input wire logic char_valid,
	input wire logic [7:0] char_data,
	// decoded command and error pulses
	output logic cmd_valid,
	output icp_cmd_t cmd,
	output logic cmd_error
);

	//////////////////////////////////////////////////////////////////////
	// state
	icp_state_t state_q, state_d;
	icp_node_t cur_q, cur_d, leaf_q, leaf_d;
	logic query_q, query_d;
	logic [7:0] kbuf_q [KW_CHARS];
	logic [7:0] kbuf_d [KW_CHARS];
	logic [3:0] klen_q, klen_d;
	logic num_q, num_d, dot_q, dot_d, e_q, e_d, eneg_q, eneg_d;
	logic mneg_q, mneg_d;
	logic [31:0] mant_q, mant_d;
	logic [7:0] frac_q, frac_d, exp_q, exp_d;
	logic cmd_valid_q, cmd_valid_d, err_q, err_d;
	icp_cmd_t cmd_q, cmd_d;

	//////////////////////////////////////////////////////////////////////
	// character classes; folding to upper case makes matching case-blind
	logic [7:0] c;
	logic is_dig, is_alpha, is_term;
	always_comb begin
		c = char_data;
		if (char_data >= CH_LA && char_data <= CH_LZ) begin
			c = char_data - CASE_GAP;
		end
		is_dig = (c >= CH_0) && (c <= CH_9);
		is_alpha = (c >= CH_UA) && (c <= CH_UZ);
		is_term = (c == CH_SEMI) || (c == CH_LF);
	end

	//////////////////////////////////////////////////////////////////////
	// keyword match, one comparator per table entry
	icp_node_t ctx;
	logic [KW_ENTRIES-1:0] hit;
	logic hit_any;
	icp_node_t hit_node;

	// common commands match from any level; parameters match the word set
	always_comb begin
		if (state_q == ST_PARAM) begin
			ctx = NODE_WORDS;
		end else if (kbuf_q[0] == CH_STAR) begin
			ctx = NODE_ROOT;
		end else begin
			ctx = cur_q;
		end
	end

	for (genvar e = 0; e < KW_ENTRIES; e++) begin : g_kw
		logic eq;
		always_comb begin
			eq = 1'b1;
			for (int i = 0; i < KW_CHARS; i++) begin
				if (i < int'(klen_q) && i < int'(KW_TABLE[e].flen) &&
					kbuf_q[i] != 8'(KW_TABLE[e].text >>
					(8 * (int'(KW_TABLE[e].flen) - 1 - i)))) begin
					eq = 1'b0;
				end
			end
		end
		// exact short or exact full length only; truncations fail
		assign hit[e] = eq && klen_q != 4'h0 &&
			(klen_q == KW_TABLE[e].slen || klen_q == KW_TABLE[e].flen) &&
			(KW_TABLE[e].parent == ctx ||
			(ctx == NODE_ROOT && KW_TABLE[e].parent == NODE_SRC));
	end

	// lowest entry wins, so an explicit root keyword beats an implied one
	always_comb begin
		hit_any = |hit;
		hit_node = NODE_ROOT;
		for (int e = KW_ENTRIES - 1; e >= 0; e--) begin
			if (hit[e]) begin
				hit_node = 5'(e + 1);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// next state
	logic finish, fail;
	icp_kw_t ent;
	always_comb begin
		state_d = state_q;
		cur_d = cur_q;
		leaf_d = leaf_q;
		query_d = query_q;
		kbuf_d = kbuf_q;
		klen_d = klen_q;
		num_d = num_q;
		dot_d = dot_q;
		e_d = e_q;
		eneg_d = eneg_q;
		mneg_d = mneg_q;
		mant_d = mant_q;
		frac_d = frac_q;
		exp_d = exp_q;
		cmd_valid_d = 1'b0;
		err_d = 1'b0;
		cmd_d = cmd_q;
		finish = 1'b0;
		fail = 1'b0;
		ent = KW_TABLE[leaf_q - NODE_FIRST];
		if (char_valid) begin
			case (state_q)
				ST_KEY: begin
					if (c == CH_COLON && klen_q == 4'h0) begin
						cur_d = NODE_ROOT;
					end else if (c == CH_COLON) begin
						fail = !hit_any;
						cur_d = hit_node;
						klen_d = 4'h0;
					end else if (c == CH_QUERY) begin
						query_d = 1'b1;
					end else if (c == CH_SPACE || is_term) begin
						if (klen_q != 4'h0) begin
							fail = !hit_any;
							finish = is_term;
							// a miss keeps leaf and entry inside the table
							if (hit_any) begin
								leaf_d = hit_node;
								ent = KW_TABLE[hit_node - NODE_FIRST];
							end
							// the space closes the keyword
							if (c == CH_SPACE && hit_any) begin
								state_d = ST_PARAM;
								klen_d = 4'h0;
							end
						end else if (c == CH_LF) begin
							// empty statement; a line end still goes home
							cur_d = NODE_ROOT;
							query_d = 1'b0;
						end
					end else if (klen_q == KW_LEN_MAX) begin
						fail = 1'b1;
					end else begin
						kbuf_d[klen_q] = c;
						klen_d = klen_q + 4'h1;
					end
				end
				ST_PARAM: begin
					if (is_term) begin
						finish = 1'b1;
					end else if (klen_q == 4'h0 && is_dig) begin
						num_d = 1'b1;
						if (e_q) begin
							exp_d = 8'(exp_q * DEC_BASE8 + (c - CH_0));
						end else begin
							mant_d = 32'(mant_q * DEC_BASE + 32'(c - CH_0));
							frac_d = frac_q + 8'(dot_q);
						end
					end else if (klen_q == 4'h0 && c == CH_DOT && !dot_q &&
						!e_q) begin
						dot_d = 1'b1;
						num_d = 1'b1;
					end else if (klen_q == 4'h0 && !num_q &&
						(c == CH_PLUS || c == CH_MINUS)) begin
						num_d = 1'b1;
						mneg_d = (c == CH_MINUS);
					end else if (e_q && exp_q == 8'h0 &&
						(c == CH_PLUS || c == CH_MINUS)) begin
						eneg_d = (c == CH_MINUS);
					end else if (num_q && !e_q && c == CH_EXP) begin
						e_d = 1'b1;
					end else if (!num_q && is_alpha && klen_q != KW_LEN_MAX) begin
						kbuf_d[klen_q] = c;
						klen_d = klen_q + 4'h1;
					end else begin
						fail = 1'b1;
					end
				end
				ST_SKIP: begin
					if (is_term) begin
						state_d = ST_KEY;
						cur_d = (c == CH_LF) ? NODE_ROOT : cur_q;
						klen_d = 4'h0;
						query_d = 1'b0;
					end
				end
				default: begin
					state_d = ST_KEY;
				end
			endcase
		end

		// classify the parameter and build the command
		if (finish && !fail) begin
			cmd_d.node = leaf_d;
			cmd_d.query = query_q;
			cmd_d.ptype = ent.ptype;
			cmd_d.pclass = PC_VALUE;
			cmd_d.bool_val = 1'b0;
			cmd_d.disc_idx = 2'h0;
			cmd_d.mant = 32'(ent.dflt);
			cmd_d.expo = 8'h0;
			if (state_q != ST_PARAM || (!num_q && klen_q == 4'h0)) begin
				if (query_q) begin
					cmd_d.pclass = PC_PRESENT;
				end else if (ent.ptype == PT_NONE) begin
					cmd_d.pclass = PC_NONE;
				end else begin
					cmd_d.pclass = PC_DEFAULT;
					cmd_d.bool_val = ent.dflt[0];
					cmd_d.disc_idx = 2'(ent.dflt);
				end
			end else if (num_q) begin
				cmd_d.mant = mneg_q ? -mant_q : mant_q;
				cmd_d.expo = (eneg_q ? -exp_q : exp_q) - frac_q;
				cmd_d.bool_val = mant_q[0];
				if (ent.ptype == PT_BOOL) begin
					fail = mant_q > 32'h1 || dot_q || e_q || mneg_q;
				end else begin
					fail = ent.ptype != PT_NUM;
				end
			end else if (hit_any && ent.ptype == PT_NUM &&
				(hit_node == NODE_MIN || hit_node == NODE_MAX)) begin
				cmd_d.pclass = (hit_node == NODE_MIN) ? PC_MIN : PC_MAX;
				cmd_d.mant = (hit_node == NODE_MIN) ? 32'(ent.lo) : 32'(ent.hi);
			end else if (hit_any && ent.ptype == PT_NUM && hit_node == NODE_DEF) begin
				cmd_d.pclass = PC_DEFAULT;
			end else if (hit_any && ent.ptype == PT_BOOL &&
				(hit_node == NODE_ON || hit_node == NODE_OFF)) begin
				cmd_d.bool_val = (hit_node == NODE_ON);
				cmd_d.mant = 32'(hit_node == NODE_ON);
			end else if (hit_any && ent.ptype == PT_DISC &&
				hit_node >= NODE_BUS && hit_node <= NODE_IMM) begin
				cmd_d.disc_idx = 2'(hit_node - NODE_BUS);
				cmd_d.mant = 32'(hit_node - NODE_BUS);
			end else begin
				fail = 1'b1;
			end
			cmd_valid_d = !fail;
		end

		// close the command; a semicolon after a good command keeps the parent level
		if (finish) begin
			state_d = ST_KEY;
			cur_d = (c == CH_LF || fail) ? NODE_ROOT : ent.parent;
			klen_d = 4'h0;
			query_d = 1'b0;
		end else if (fail) begin
			state_d = ST_SKIP;
		end
		if (finish || fail) begin
			{num_d, dot_d, e_d, eneg_d, mneg_d} = 5'h0;
			mant_d = 32'h0;
			frac_d = 8'h0;
			exp_d = 8'h0;
		end
		err_d = fail;
	end

	//////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_KEY;
			cur_q <= NODE_ROOT;
			leaf_q <= NODE_FIRST;
			query_q <= 1'b0;
			kbuf_q <= '{default: 8'h0};
			klen_q <= 4'h0;
			{num_q, dot_q, e_q, eneg_q, mneg_q} <= 5'h0;
			mant_q <= 32'h0;
			frac_q <= 8'h0;
			exp_q <= 8'h0;
			cmd_valid_q <= 1'b0;
			err_q <= 1'b0;
			cmd_q <= '0;
		end else begin
			state_q <= state_d;
			cur_q <= cur_d;
			leaf_q <= leaf_d;
			query_q <= query_d;
			kbuf_q <= kbuf_d;
			klen_q <= klen_d;
			{num_q, dot_q, e_q, eneg_q, mneg_q} <=
				{num_d, dot_d, e_d, eneg_d, mneg_d};
			mant_q <= mant_d;
			frac_q <= frac_d;
			exp_q <= exp_d;
			cmd_valid_q <= cmd_valid_d;
			err_q <= err_d;
			cmd_q <= cmd_d;
		end
	end

	assign cmd_valid = cmd_valid_q;
	assign cmd = cmd_q;
	assign cmd_error = err_q;

	//////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	AST_LINE_END_ROOT: assert property (char_valid && c == CH_LF |=>
		cur_q == NODE_ROOT && state_q == ST_KEY) else $error("lf not root");
	AST_COLON_DESCEND: assert property (state_q == ST_KEY && char_valid &&
		c == CH_COLON && hit_any |=> cur_q == $past(hit_node))
		else $error("colon did not descend");
	AST_BAD_KEY: assert property (state_q == ST_KEY && char_valid &&
		(c == CH_COLON || c == CH_SPACE) && klen_q != 4'h0 && !hit_any
		|=> cmd_error && !cmd_valid ##1 !cmd_error)
		else $error("bad keyword not flagged");
	AST_SPACE_PARAM: assert property (state_q == ST_KEY && char_valid &&
		c == CH_SPACE && hit_any |=> state_q == ST_PARAM && klen_q == 4'h0)
		else $error("space did not start parameter");
	AST_ROOT_RESTART: assert property (state_q == ST_KEY && char_valid &&
		c == CH_COLON && klen_q == 4'h0 |=> cur_q == NODE_ROOT)
		else $error("leading colon kept level");
	AST_BOOL_VALUE: assert property (cmd_valid && cmd.ptype == PT_BOOL &&
		cmd.pclass == PC_VALUE |-> cmd.mant == 32'(cmd.bool_val))
		else $error("boolean value mismatch");
	AST_DEFAULT_FILL: assert property (cmd_valid &&
		cmd.pclass == PC_DEFAULT |->
		cmd.mant == 32'(KW_TABLE[cmd.node - NODE_FIRST].dflt))
		else $error("default not substituted");
	AST_MIN_MAX: assert property (cmd_valid &&
		(cmd.pclass == PC_MIN || cmd.pclass == PC_MAX) |->
		cmd.ptype == PT_NUM && cmd.mant == ((cmd.pclass == PC_MIN) ?
		32'(KW_TABLE[cmd.node - NODE_FIRST].lo) :
		32'(KW_TABLE[cmd.node - NODE_FIRST].hi)))
		else $error("limit not substituted");
	AST_QUERY_PRESENT: assert property (state_q == ST_KEY &&
		char_valid && is_term && klen_q != 4'h0 && hit_any && query_q
		|=> cmd_valid && cmd.pclass == PC_PRESENT)
		else $error("bare query not present");
	AST_DISC_SET: assert property (cmd_valid && cmd.ptype == PT_DISC |->
		cmd.disc_idx <= 2'(NODE_IMM - NODE_BUS))
		else $error("discrete outside set");
	AST_ONE_ANSWER: assert property (!(cmd_valid && cmd_error))
		else $error("command and error together");

	COV_QUERY: cover property (cmd_valid && cmd.query);
	COV_ERROR: cover property (cmd_error);
	COV_MIN: cover property (cmd_valid && cmd.pclass == PC_MIN);
	COV_CHAIN: cover property (cmd_valid ##[1:40] cmd_valid);

endmodule

// file: icp_pkg.sv
// icp_pkg: shared types, character codes and keyword table of the parser.
// assumes one ASCII character per cycle from same-clock logic.
package icp_pkg;

	//////////////////////////////////////////////////////////////////////
	// sizes and character codes
	localparam int KW_CHARS = 12;
	localparam int KW_ENTRIES = 22;
	localparam logic [3:0] KW_LEN_MAX = 4'hc;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_PLUS = 8'h2b;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_EXP = 8'h45;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UZ = 8'h5a;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LZ = 8'h7a;
	localparam logic [7:0] CASE_GAP = 8'h20;
	localparam logic [31:0] DEC_BASE = 32'h0000000a;
	localparam logic [7:0] DEC_BASE8 = 8'h0a;

	//////////////////////////////////////////////////////////////////////
	// tree nodes: entry e of the table is node e+1
	typedef logic [4:0] icp_node_t;
	localparam icp_node_t NODE_ROOT = 5'h00;
	localparam icp_node_t NODE_FIRST = 5'h01;
	localparam icp_node_t NODE_SRC = 5'h01;
	localparam icp_node_t NODE_MIN = 5'h0f;
	localparam icp_node_t NODE_MAX = 5'h10;
	localparam icp_node_t NODE_DEF = 5'h11;
	localparam icp_node_t NODE_ON = 5'h12;
	localparam icp_node_t NODE_OFF = 5'h13;
	localparam icp_node_t NODE_BUS = 5'h14;
	localparam icp_node_t NODE_IMM = 5'h16;
	localparam icp_node_t NODE_WORDS = 5'h1f;

	typedef enum logic [1:0] {PT_NONE, PT_NUM, PT_BOOL, PT_DISC} icp_ptype_t;
	typedef enum logic [2:0] {PC_NONE, PC_VALUE, PC_MIN, PC_MAX, PC_DEFAULT,
		PC_PRESENT} icp_pclass_t;
	typedef enum logic [2:0] {ST_KEY = 3'b001, ST_PARAM = 3'b010,
		ST_SKIP = 3'b100} icp_state_t;

	typedef struct packed {
		logic [95:0] text;
		logic [3:0] slen;
		logic [3:0] flen;
		icp_node_t parent;
		icp_ptype_t ptype;
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		logic signed [15:0] dflt;
	} icp_kw_t;

	typedef struct packed {
		icp_node_t node;
		logic query;
		icp_ptype_t ptype;
		icp_pclass_t pclass;
		logic bool_val;
		logic [1:0] disc_idx;
		logic signed [31:0] mant;
		logic signed [7:0] expo;
	} icp_cmd_t;

	// text right-justified, upper case; slen is the short-form length
	localparam icp_kw_t KW_TABLE [KW_ENTRIES] = '{
		'{96'("SOURCE"), 4'h4, 4'h6, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("FREQUENCY"), 4'h4, 4'h9, 5'h01, PT_NUM,
			16'sh0001, 16'sh3e80, 16'sh03e8},
		'{96'("VOLTAGE"), 4'h4, 4'h7, 5'h01, PT_NUM,
			16'sh0001, 16'sh000a, 16'sh0001},
		'{96'("OFFSET"), 4'h4, 4'h6, 5'h03, PT_NUM,
			16'shfffb, 16'sh0005, 16'sh0000},
		'{96'("AM"), 4'h2, 4'h2, 5'h01, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("DEPTH"), 4'h4, 4'h5, 5'h05, PT_NUM,
			16'sh0000, 16'sh0078, 16'sh0064},
		'{96'("TRIGGER"), 4'h4, 4'h7, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("SOURCE"), 4'h4, 4'h6, 5'h07, PT_DISC,
			16'sh0000, 16'sh0002, 16'sh0000},
		'{96'("OUTPUT"), 4'h4, 4'h6, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("SYNC"), 4'h4, 4'h4, 5'h09, PT_BOOL,
			16'sh0000, 16'sh0001, 16'sh0000},
		'{96'("*RST"), 4'h4, 4'h4, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("*CLS"), 4'h4, 4'h4, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("*ESR"), 4'h4, 4'h4, 5'h00, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("*SAV"), 4'h4, 4'h4, 5'h00, PT_NUM,
			16'sh0000, 16'sh0003, 16'sh0000},
		'{96'("MINIMUM"), 4'h3, 4'h7, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("MAXIMUM"), 4'h3, 4'h7, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("DEFAULT"), 4'h3, 4'h7, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("ON"), 4'h2, 4'h2, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("OFF"), 4'h3, 4'h3, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("BUS"), 4'h3, 4'h3, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("EXTERNAL"), 4'h3, 4'h8, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0},
		'{96'("IMMEDIATE"), 4'h3, 4'h9, 5'h1f, PT_NONE, 16'sh0, 16'sh0, 16'sh0}
	};

endpackage

// file: icp_host_model.sv
// icp_host_model: host computer that sends command text to the parser.
// assumes the parser takes one character on every edge with valid high.
`timescale 1ns/1ns
module icp_host_model (
	// clock
	input wire logic ref_clk,
	// character stream toward the parser
	output logic char_valid,
	output logic [7:0] char_data
);

	//////////////////////////////////////////////////////////////////////
	// idle at time zero, nothing offered
	initial begin
		char_valid = 1'b0;
		char_data = 8'h00;
	end

	//////////////////////////////////////////////////////////////////////
	// text goes out verbatim, so the bench writes the separators itself
	// slow mode drops valid after some characters to show stalls
	// idle data is the inverse of the last character, never a stale copy
	task automatic send_line(input string s, input bit slow);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge ref_clk);
			char_valid <= 1'b1;
			char_data <= s[i];
			if (slow && (i % 3 == 1)) begin
				@(posedge ref_clk);
				char_valid <= 1'b0;
				char_data <= ~s[i];
			end
		end
		@(posedge ref_clk);
		char_valid <= 1'b0;
		char_data <= ~s[s.len() - 1];
	endtask

endmodule

// file: instrument_command_parser_test.sv
// instrument_command_parser_test: self-checking bench of the parser.
// assumes the host model drives the character stream; results are
// checked against a queue of expected commands filled by each test.
`timescale 1ns/1ns
module instrument_command_parser_test
	import icp_pkg::*;
;
	logic ref_clk;
	logic rst_b;
	logic char_valid;
	logic [7:0] char_data;
	logic cmd_valid;
	logic cmd_error;
	icp_cmd_t cmd;
	int num_errors;
	int cmp_count;
	int cycles;
	int seed;
	int a;
	int b;
	int x;
	logic neg;
	icp_cmd_t exp_q[$];
	logic err_q[$];
	icp_cmd_t e_x;
	logic e_err;

	//////////////////////////////////////////////////////////////////////
	// clock, reset and instances
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;

	icp_parser u_icp_parser (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.char_valid(char_valid),
		.char_data(char_data),
		.cmd_valid(cmd_valid),
		.cmd(cmd),
		.cmd_error(cmd_error)
	);

	icp_host_model u_icp_host_model (
		.ref_clk(ref_clk),
		.char_valid(char_valid),
		.char_data(char_data)
	);

	//////////////////////////////////////////////////////////////////////
	// comparison, expectation and reporting tasks
	task automatic chk(input string name, input logic [31:0] ev,
		input logic [31:0] gv);
		cmp_count++;
		if (gv !== ev) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, ev, gv);
		end
	endtask

	// m carries the number, the boolean or the discrete index
	task automatic exp_cmd(input icp_node_t n, input bit q,
		input icp_pclass_t c, input int m, input int e);
		icp_cmd_t t;
		t = '0;
		t.node = n;
		t.query = q;
		t.ptype = KW_TABLE[n - 1].ptype;
		t.pclass = c;
		t.mant = m;
		t.expo = e[7:0];
		t.bool_val = m[0];
		t.disc_idx = m[1:0];
		exp_q.push_back(t);
		err_q.push_back(1'b0);
	endtask

	task automatic exp_err();
		exp_q.push_back('0);
		err_q.push_back(1'b1);
	endtask

	task automatic send(input string s, input bit slow);
		u_icp_host_model.send_line(s, slow);
	endtask

	// answers come one cycle after the terminator, four is ample
	task automatic done_test(input string name);
		repeat (4) @(posedge ref_clk);
		chk("pending", 32'h0, exp_q.size());
		$display("test %s done", name);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////
	// monitor: every pulse must match the oldest expectation
	// sampled on the falling edge so registered outputs have settled
	always @(negedge ref_clk) begin
		if (cmd_valid === 1'b1 || cmd_error === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected_pulse", 32'h0, 32'h1);
			end else begin
				e_x = exp_q.pop_front();
				e_err = err_q.pop_front();
				chk("cmd_error", e_err, cmd_error);
				chk("cmd_valid", !e_err, cmd_valid);
				if (!e_err) begin
					chk("node", e_x.node, cmd.node);
					chk("query", e_x.query, cmd.query);
					chk("ptype", e_x.ptype, cmd.ptype);
					chk("pclass", e_x.pclass, cmd.pclass);
					if (e_x.pclass inside {PC_VALUE, PC_MIN, PC_MAX,
						PC_DEFAULT}) begin
						if (e_x.ptype == PT_NUM) begin
							chk("mant", e_x.mant, cmd.mant);
							chk("expo", e_x.expo, cmd.expo);
						end
						if (e_x.ptype == PT_BOOL)
							chk("bool_val", e_x.bool_val, cmd.bool_val);
						if (e_x.ptype == PT_DISC)
							chk("disc_idx", e_x.disc_idx, cmd.disc_idx);
					end
				end
			end
		end
	end

	// hang guard, far above the fewer than one thousand cycles the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	//////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		seed = 81386;
		rst_b = 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk("reset_valid", 32'h0, cmd_valid);
		chk("reset_error", 32'h0, cmd_error);
		// common commands and the space before a parameter
		exp_cmd(5'h0b, 1'b0, PC_NONE, 0, 0);
		exp_cmd(5'h0e, 1'b0, PC_VALUE, 2, 0);
		exp_cmd(5'h0e, 1'b1, PC_PRESENT, 0, 0);
		exp_err();
		send("*RST\n*SAV 2\n*SAV?\n*SAV2\n", 1'b0);
		exp_cmd(5'h0d, 1'b0, PC_NONE, 0, 0);
		send("*ESR\n", 1'b1);
		done_test("common");
		// tree descent, implied root, short and full forms, case
		exp_cmd(5'h02, 1'b0, PC_VALUE, 15, 2);
		exp_cmd(5'h02, 1'b0, PC_VALUE, 7, 0);
		exp_cmd(5'h02, 1'b0, PC_VALUE, 7, 0);
		exp_cmd(5'h04, 1'b0, PC_VALUE, -2, 0);
		exp_err();
		exp_err();
		send("SOUR:FREQ 1.5E3\nFREQUENCY 7\nfReQ 7\n", 1'b1);
		send("sour:voltage:offs -2\nFREQU 7\nFREQUEN\n", 1'b0);
		// implied root on a node that also has a child, then a keyword one char too long
		exp_cmd(5'h03, 1'b0, PC_VALUE, 5, 0);
		exp_err();
		send("VOLT 5\nABCDEFGHIJKLM\n", 1'b0);
		done_test("keywords");
		// fixed and random numeric forms
		exp_cmd(5'h02, 1'b0, PC_VALUE, 123, 2);
		exp_cmd(5'h04, 1'b0, PC_VALUE, -123, -2);
		exp_cmd(5'h04, 1'b0, PC_VALUE, 123, -4);
		exp_cmd(5'h04, 1'b0, PC_VALUE, 123, -3);
		send("FREQ 123E2\nVOLT:OFFS -1.23E0\n", 1'b0);
		send("VOLT:OFFS 1.23E-2\nVOLT:OFFS .123\n", 1'b1);
		for (int k = 0; k < 8; k++) begin
			a = {$random(seed)} % 5;
			b = {$random(seed)} % 10;
			x = {$random(seed)} % 3;
			neg = ({$random(seed)} % 2) == 1;
			exp_cmd(5'h04, 1'b0, PC_VALUE, neg ? -(a * 10 + b) : a * 10 + b,
				-x - 1);
			send($sformatf("VOLT:OFFS %s%0d.%0dE-%0d\n", neg ? "-" : "+",
				a, b, x), k[0]);
		end
		// only one parameter: a comma is refused
		exp_err();
		send("FREQ 1,2\n", 1'b0);
		done_test("numbers");
		// substitute keywords, defaults and queries
		exp_cmd(5'h02, 1'b0, PC_MIN, 1, 0);
		exp_cmd(5'h02, 1'b0, PC_MAX, 16000, 0);
		exp_cmd(5'h02, 1'b0, PC_DEFAULT, 1000, 0);
		exp_cmd(5'h06, 1'b0, PC_DEFAULT, 100, 0);
		exp_cmd(5'h06, 1'b1, PC_PRESENT, 0, 0);
		exp_cmd(5'h06, 1'b1, PC_MIN, 0, 0);
		exp_cmd(5'h06, 1'b1, PC_MAX, 120, 0);
		send("FREQ MIN\nFREQ MAXIMUM\nFREQ DEF\nAM:DEPT\n", 1'b0);
		send("AM:DEPT?\nAM:DEPTH? MIN\nam:depth? max\n", 1'b1);
		done_test("substitutes");
		// booleans, discrete settings and their defaults
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 0, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 0, 0);
		exp_err();
		exp_cmd(5'h0a, 1'b0, PC_DEFAULT, 0, 0);
		send("OUTP:SYNC ON\nOUTP:SYNC OFF\nOUTP:SYNC 1\nOUTP:SYNC 0\n", 0);
		send("OUTP:SYNC 2\nOUTP:SYNC\n", 1'b1);
		exp_err();
		send("OUTP:SYNC -1\n", 1'b0);
		exp_cmd(5'h08, 1'b0, PC_VALUE, 0, 0);
		exp_cmd(5'h08, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h08, 1'b0, PC_VALUE, 2, 0);
		exp_err();
		exp_cmd(5'h08, 1'b0, PC_DEFAULT, 0, 0);
		send("TRIG:SOUR BUS\nTRIG:SOUR EXTERNAL\nTRIG:SOUR IMM\n", 0);
		send("TRIG:SOUR ON\nTRIG:SOUR\n", 1'b0);
		done_test("parameters");
		// chained statements, root restart and line end
		exp_cmd(5'h0b, 1'b0, PC_NONE, 0, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h08, 1'b0, PC_VALUE, 0, 0);
		exp_cmd(5'h0c, 1'b0, PC_NONE, 0, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h08, 1'b0, PC_VALUE, 1, 0);
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_err();
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_err();
		send("*RST;OUTP:SYNC ON\nTRIG:SOUR BUS;*CLS\n", 1'b1);
		send("OUTP:SYNC ON;:TRIG:SOUR EXT\n", 1'b0);
		send("OUTP:SYNC ON;TRIG:SOUR EXT\nOUTP:SYNC 1\nSYNC 1\n", 1'b0);
		// an empty statement before the line end must still go to root
		exp_cmd(5'h0a, 1'b0, PC_VALUE, 1, 0);
		exp_err();
		send("OUTP:SYNC ON;\nSYNC 1\n", 1'b0);
		done_test("chaining");
		// reset in mid-line must drop the partial tree position
		send("OUTP:", 1'b0);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		chk("reset_valid", 32'h0, cmd_valid);
		chk("reset_error", 32'h0, cmd_error);
		chk("reset_node", 32'h0, cmd.node);
		exp_err();
		send("SYNC 1\n", 1'b0);
		done_test("reset");
		final_report();
	end

endmodule
